// *** hdl/osc_output_signal_control.sv ***
`timescale 1ns/1ns
`include "osc_defines.svh"
module osc_output_signal_control
    import osc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`OSC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`OSC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic horizontal_sync_in,
    input wire logic vertical_sync_in,
    input wire logic external_red_in,
    input wire logic external_green_in,
    input wire logic external_blue_in,
    input wire logic external_luma_blank_in,
    input wire osc_engine_t engine_in,
    input wire logic display_area,
    input wire logic display_line_end,
    input wire osc_pins_t port_data,
    output osc_pins_t pins_out,
    output logic [7:0] engine_hstart,
    output logic engine_double_scan,
    output logic engine_load,
    output logic char_start,
    output logic [9:0] vertical_count,
    output logic hsync_fall,
    output logic vsync_fall
);

    localparam logic [5:0] XFER_DELAY = 6'(`OSC_XFER_DELAY_CYC);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] pin_select_reg;
    logic [7:0] polarity_reg;
    logic [7:0] area_colour_reg;
    logic [7:0] scan_format_reg;
    logic [7:0] hstart_reg;
    logic [7:0] display_ctrl_reg;
    logic [7:0] port_fixed_reg;
    logic xfer_busy_reg;
    osc_xfer_state_t xfer_state_reg;
    logic [5:0] xfer_cnt_reg;

    // index decode, shared by read and write paths
    function automatic logic [2:0] reg_sel(input logic [`OSC_ADDR_W-1:0] addr);
        logic [11:0] idx;
        idx = addr[`OSC_ADDR_W-1:2];
        case (idx)
            `OSC_IDX_PIN_SELECT: reg_sel = 3'h1;
            `OSC_IDX_POLARITY: reg_sel = 3'h2;
            `OSC_IDX_AREA_COLOUR: reg_sel = 3'h3;
            `OSC_IDX_SCAN_FORMAT: reg_sel = 3'h4;
            `OSC_IDX_HSTART: reg_sel = 3'h5;
            `OSC_IDX_DISPLAY_CTRL: reg_sel = 3'h6;
            `OSC_IDX_PORT_FIXED: reg_sel = 3'h7;
            default: reg_sel = 3'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // axi write channel

    logic aw_held_reg;
    logic w_held_reg;
    logic [`OSC_ADDR_W-1:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic w_strb_reg;
    logic wr_fire;
    logic [2:0] wr_sel;

    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_sel = reg_sel(aw_addr_reg);

    // address and data latch independently, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_strb_reg <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // write response one cycle after both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // register stores; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_select_reg <= `OSC_RST_REG;
            polarity_reg <= `OSC_RST_REG;
            area_colour_reg <= `OSC_RST_REG;
            scan_format_reg <= `OSC_RST_REG;
            hstart_reg <= `OSC_RST_REG;
            display_ctrl_reg <= `OSC_RST_REG;
            port_fixed_reg <= `OSC_RST_REG;
        end else if (wr_fire && w_strb_reg) begin
            case (wr_sel)
                3'h1: pin_select_reg <= w_data_reg;
                3'h2: polarity_reg <= w_data_reg;
                3'h3: area_colour_reg <= w_data_reg;
                3'h4: scan_format_reg <= w_data_reg;
                3'h5: hstart_reg <= w_data_reg;
                3'h6: display_ctrl_reg <= w_data_reg;
                3'h7: port_fixed_reg <= w_data_reg;
                default: pin_select_reg <= pin_select_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi read channel

    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        case (reg_sel(s_axi_araddr))
            3'h1: rd_byte = pin_select_reg;
            3'h2: rd_byte = polarity_reg;
            3'h3: rd_byte = area_colour_reg;
            3'h4: rd_byte = scan_format_reg;
            3'h5: rd_byte = hstart_reg;
            3'h6: rd_byte = {display_ctrl_reg[7:3], xfer_busy_reg, display_ctrl_reg[1:0]};
            3'h7: rd_byte = port_fixed_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    // read answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= (reg_sel(s_axi_araddr) == 3'h0) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic hs_level_reg;
    logic vs_level_reg;
    logic hs_fall;
    logic vs_fall;

    // only the second stage is read anywhere
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end else begin
            sync1_reg <= {vertical_sync_in, horizontal_sync_in, external_luma_blank_in,
                external_blue_in, external_green_in, external_red_in};
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_level_reg <= 1'b0;
            vs_level_reg <= 1'b0;
        end else begin
            hs_level_reg <= sync2_reg[4] ^ polarity_reg[`OSC_BIT_HS_INV];
            vs_level_reg <= sync2_reg[5] ^ polarity_reg[`OSC_BIT_VS_INV];
        end
    end

    assign hs_fall = hs_level_reg && !(sync2_reg[4] ^ polarity_reg[`OSC_BIT_HS_INV]);
    assign vs_fall = vs_level_reg && !(sync2_reg[5] ^ polarity_reg[`OSC_BIT_VS_INV]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hsync_fall <= 1'b0;
            vsync_fall <= 1'b0;
        end else begin
            hsync_fall <= hs_fall;
            vsync_fall <= vs_fall;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer request sequencer

    logic req_write;

    // writing 0 is ignored so a busy transfer can not be cancelled
    assign req_write = wr_fire && w_strb_reg && (wr_sel == 3'h6)
        && w_data_reg[`OSC_BIT_XFER_REQ];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xfer_state_reg <= OSC_XFER_IDLE;
            xfer_cnt_reg <= 6'h00;
            xfer_busy_reg <= 1'b0;
            engine_load <= 1'b0;
        end else begin
            engine_load <= 1'b0;
            case (xfer_state_reg)
                OSC_XFER_IDLE: begin
                    if (req_write) begin
                        xfer_state_reg <= OSC_XFER_DELAY;
                        xfer_cnt_reg <= XFER_DELAY;
                        xfer_busy_reg <= 1'b1;
                    end
                end
                OSC_XFER_DELAY: begin
                    if (xfer_cnt_reg > 6'h01) begin
                        xfer_cnt_reg <= xfer_cnt_reg - 6'h01;
                    end else if (display_area) begin
                        xfer_state_reg <= OSC_XFER_WAIT_LINE;
                    end else begin
                        xfer_state_reg <= OSC_XFER_WAIT_HS;
                    end
                end
                OSC_XFER_WAIT_LINE: begin
                    if (display_line_end) begin
                        xfer_state_reg <= OSC_XFER_WAIT_HS;
                    end
                end
                OSC_XFER_WAIT_HS: begin
                    if (hs_fall) begin
                        xfer_state_reg <= OSC_XFER_IDLE;
                        engine_load <= 1'b1;
                        // a request landing here still wins over the clear
                        xfer_busy_reg <= req_write;
                        if (req_write) begin
                            xfer_state_reg <= OSC_XFER_DELAY;
                            xfer_cnt_reg <= XFER_DELAY;
                        end
                    end
                end
                default: xfer_state_reg <= OSC_XFER_IDLE;
            endcase
        end
    end

    // horizontal start shadow loads only on transfer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            engine_hstart <= 8'h00;
        end else if (xfer_state_reg == OSC_XFER_WAIT_HS && hs_fall) begin
            engine_hstart <= hstart_reg;
        end
    end

    // scan format bypasses the transfer path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            engine_double_scan <= 1'b0;
        end else begin
            engine_double_scan <= scan_format_reg[`OSC_BIT_DOUBLE_SCAN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dot and line counting

    logic [9:0] dot_cnt_reg;
    logic line_phase_reg;
    logic [9:0] hstart_dots;

    // value times two plus fixed offset
    assign hstart_dots = {1'b0, engine_hstart, 1'b0} + `OSC_HSTART_OFFSET;

    // counter saturates so a lost sync can not wrap into a false start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dot_cnt_reg <= 10'h000;
            char_start <= 1'b0;
        end else begin
            char_start <= !hs_fall && (dot_cnt_reg == hstart_dots);
            if (hs_fall) begin
                dot_cnt_reg <= 10'h000;
            end else if (dot_cnt_reg != 10'h3ff) begin
                dot_cnt_reg <= dot_cnt_reg + 10'h001;
            end
        end
    end

    // double scan counts every second line
    // the same count sets the vertical start unit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vertical_count <= 10'h000;
            line_phase_reg <= 1'b0;
        end else if (vs_fall) begin
            vertical_count <= 10'h000;
            line_phase_reg <= 1'b0;
        end else if (hs_fall) begin
            line_phase_reg <= !line_phase_reg;
            if (!scan_format_reg[`OSC_BIT_DOUBLE_SCAN] || line_phase_reg) begin
                vertical_count <= vertical_count + 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin output path

    logic int_luma;
    logic int_blank;
    logic int_lb;
    logic [3:0] int_col;
    logic [3:0] ext_col;
    logic [3:0] mux_col;
    logic [3:0] pin_col;
    logic int_intensity;
    logic [3:0] out_inv;

    assign int_luma = engine_in.red | engine_in.green | engine_in.blue
        | engine_in.char_dot | engine_in.fringe_dot | engine_in.area_dot;
    assign int_blank = display_ctrl_reg[`OSC_BIT_FULL_PAGE] ? engine_in.page_area
        : engine_in.char_area;
    // luma or blank choice; bit 7 also selects port data for the shared pin, so blank never reaches it
    assign int_lb = pin_select_reg[`OSC_BIT_LB_CHOICE] ? int_blank : int_luma;
    assign int_col = {int_lb, engine_in.blue, engine_in.green, engine_in.red};
    assign ext_col = {sync2_reg[3] ^ polarity_reg[`OSC_BIT_LB_IN_INV],
        sync2_reg[2:0] ^ {3{polarity_reg[`OSC_BIT_COL_IN_INV]}}};
    // intensity only in enabled area planes
    assign int_intensity = (engine_in.area1 & area_colour_reg[`OSC_BIT_AREA1_INT])
        | (engine_in.area2 & area_colour_reg[`OSC_BIT_AREA2_INT]);

    // source selector, priority by the luma/blank lead signal
    always_comb begin
        mux_col = int_col;
        case (pin_select_reg[1:0])
            2'b00: mux_col = int_col[3] ? int_col : ext_col;
            2'b01: mux_col = int_col;
            2'b10: mux_col = ext_col;
            2'b11: mux_col = ext_col[3] ? ext_col : int_col;
            default: mux_col = int_col;
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_col_sel
            assign pin_col[gi] = pin_select_reg[`OSC_BIT_RED_SEL + gi] ? port_data[4 - gi]
                : mux_col[gi];
        end
    endgenerate

    // luma/blank pin inverts by the blank polarity bit when bit 7 is set, which also routes port data, else by the luma bit
    assign out_inv = {pin_select_reg[`OSC_BIT_LB_CHOICE] ? polarity_reg[`OSC_BIT_BLANK_OUT_INV]
        : polarity_reg[`OSC_BIT_LUMA_OUT_INV], {3{polarity_reg[`OSC_BIT_COL_OUT_INV]}}};

    // applied last, directly at the pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_out <= '0;
        end else begin
            pins_out.red <= pin_col[0] ^ out_inv[0];
            pins_out.green <= pin_col[1] ^ out_inv[1];
            pins_out.blue <= pin_col[2] ^ out_inv[2];
            pins_out.luma_blank <= pin_col[3] ^ out_inv[3];
            pins_out.intensity <= (pin_select_reg[`OSC_BIT_INTENSITY_SEL] ? port_data.intensity
                : int_intensity) ^ polarity_reg[`OSC_BIT_INT_OUT_INV];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_intensity_area: assert property (@(posedge aclk) disable iff (!aresetn)
        (!pin_select_reg[3] && !polarity_reg[0] && !engine_in.area1 && !engine_in.area2)
        |=> !pins_out.intensity)
        else $error("intensity high outside area planes");
    a_port_route: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_select_reg[3] && !polarity_reg[0])
        |=> pins_out.intensity == $past(port_data.intensity))
        else $error("intensity pin not carrying port data");
    a_red_invert: assert property (@(posedge aclk) disable iff (!aresetn)
        (pin_select_reg[4] && polarity_reg[1]) |=> pins_out.red == !$past(port_data.red))
        else $error("red pin polarity wrong");
    a_xfer_outside: assert property (@(posedge aclk) disable iff (!aresetn)
        (xfer_state_reg == OSC_XFER_WAIT_HS && hs_fall)
        |=> engine_load && (xfer_busy_reg == $past(req_write)))
        else $error("transfer did not complete on hsync fall");
    a_busy_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        req_write && xfer_state_reg == OSC_XFER_IDLE |=> xfer_busy_reg [*8])
        else $error("busy flag dropped early");
    a_no_early_load: assert property (@(posedge aclk) disable iff (!aresetn)
        req_write && xfer_state_reg == OSC_XFER_IDLE |=> !engine_load [*8])
        else $error("transfer started before delay");
    a_line_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        xfer_state_reg == OSC_XFER_WAIT_LINE |=> !engine_load)
        else $error("transfer inside a running line");
    a_hstart_shadow: assert property (@(posedge aclk) disable iff (!aresetn)
        !engine_load |=> $stable(engine_hstart) || $past(engine_load) || engine_load)
        else $error("horizontal start changed without transfer");
    a_double_count: assert property (@(posedge aclk) disable iff (!aresetn)
        (hs_fall && !vs_fall && scan_format_reg[7] && !line_phase_reg) |=> $stable(vertical_count))
        else $error("double scan advanced on first line");
    a_scan_direct: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 engine_double_scan == $past(scan_format_reg[7]))
        else $error("scan mode did not follow register");

endmodule

// *** include/osc_defines.svh ***
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

// register indices; byte address is four times the index
`define OSC_IDX_PIN_SELECT 12'h000
`define OSC_IDX_POLARITY 12'h001
`define OSC_IDX_AREA_COLOUR 12'h002
`define OSC_IDX_SCAN_FORMAT 12'h003
`define OSC_IDX_HSTART 12'h004
`define OSC_IDX_DISPLAY_CTRL 12'h005
`define OSC_IDX_PORT_FIXED 12'hfa1
`define OSC_ADDR_W 14

// field positions
`define OSC_BIT_INTENSITY_SEL 3
`define OSC_BIT_RED_SEL 4
`define OSC_BIT_GREEN_SEL 5
`define OSC_BIT_BLUE_SEL 6
`define OSC_BIT_LB_SEL 7
`define OSC_BIT_LB_CHOICE 7
`define OSC_BIT_FULL_PAGE 3
`define OSC_BIT_INT_OUT_INV 0
`define OSC_BIT_COL_OUT_INV 1
`define OSC_BIT_LUMA_OUT_INV 2
`define OSC_BIT_BLANK_OUT_INV 3
`define OSC_BIT_COL_IN_INV 4
`define OSC_BIT_LB_IN_INV 5
`define OSC_BIT_HS_INV 6
`define OSC_BIT_VS_INV 7
`define OSC_BIT_AREA1_INT 3
`define OSC_BIT_AREA2_INT 7
`define OSC_BIT_DOUBLE_SCAN 7
`define OSC_BIT_XFER_REQ 2

// reset value, and the fixed port value the test writes
`define OSC_RST_REG 8'h00
`define OSC_PORT_FIXED_VALUE 8'h0e

// timing
`define OSC_CLK_NS 20
`define OSC_INSTR_NS 250
`define OSC_XFER_INSTR 3
`define OSC_XFER_DELAY_CYC ((`OSC_XFER_INSTR * `OSC_INSTR_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS)
`define OSC_HSTART_OFFSET 10'd22
`endif

// *** include/osc_pkg.sv ***
package osc_pkg;
    // display engine signals for the current dot
    typedef struct packed {
        logic red;
        logic green;
        logic blue;
        logic char_dot;
        logic fringe_dot;
        logic area_dot;
        logic area1;
        logic area2;
        logic char_area;
        logic page_area;
    } osc_engine_t;

    // pin levels, red/green/blue/luma-blank/intensity
    typedef struct packed {
        logic red;
        logic green;
        logic blue;
        logic luma_blank;
        logic intensity;
    } osc_pins_t;

    typedef enum logic [1:0] {
        OSC_XFER_IDLE,
        OSC_XFER_DELAY,
        OSC_XFER_WAIT_LINE,
        OSC_XFER_WAIT_HS
    } osc_xfer_state_t;
endpackage

// *** verif/osc_output_signal_control_test.sv ***
`timescale 1ns/1ns
`include "osc_defines.svh"
module osc_output_signal_control_test;
    import osc_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [13:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid, hs_n, vs_n, dscan, load;
    logic [1:0] bresp, rresp;
    logic [3:0] ext = 0;
    osc_engine_t eng = '0;
    osc_pins_t port = '0, pins;
    logic [7:0] hstart, rd;
    logic da = 0, dle = 0, cstart, hfall, vfall;
    logic [9:0] vcount;
    logic [4:0] mix [4] = '{5'h13, 5'h13, 5'h0b, 5'h0b};
    int bad_count = 0, total_checks = 0, cyc = 0, n;
    always #10 aclk = ~aclk;
    osc_sync_source i_osc_sync_source (.aclk(aclk), .hsync_n(hs_n), .vsync_n(vs_n));
    osc_output_signal_control i_osc_output_signal_control (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .horizontal_sync_in(hs_n), .vertical_sync_in(vs_n),
        .external_red_in(ext[3]), .external_green_in(ext[2]), .external_blue_in(ext[1]),
        .external_luma_blank_in(ext[0]), .engine_in(eng), .display_area(da),
        .display_line_end(dle), .port_data(port), .pins_out(pins), .engine_hstart(hstart),
        .engine_double_scan(dscan), .engine_load(load), .char_start(cstart),
        .vertical_count(vcount), .hsync_fall(hfall), .vsync_fall(vfall));
    // compare and count; x never matches
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // write one word, holding each channel until taken
    task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        chk("bresp", bresp, er);
    endtask
    task automatic rdr(input logic [11:0] idx, output logic [7:0] d);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        d = rdata[7:0];
    endtask
    // wait for the transfer pulse, bounded
    task automatic wait_load;
        n = 0;
        while (!load && n < 300) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard, twenty thousand cycles is ample
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            finish_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        wr(`OSC_IDX_PORT_FIXED, `OSC_PORT_FIXED_VALUE, 2'b00);
        rdr(`OSC_IDX_PORT_FIXED, rd);
        chk("fixed", rd, 8'h0e);
        wr(12'h0ff, 8'h55, 2'b10);
        eng.red <= 1;
        ext <= 4'h5;
        wr(`OSC_IDX_PIN_SELECT, 8'h01, 2'b00);
        repeat (4) @(posedge aclk);
        chk("internal", pins, 5'h12);
        wr(`OSC_IDX_POLARITY, 8'h0f, 2'b00);
        repeat (4) @(posedge aclk);
        chk("inverted", pins, 5'h0d);
        eng.area1 <= 1;
        wr(`OSC_IDX_POLARITY, 8'h00, 2'b00);
        wr(`OSC_IDX_AREA_COLOUR, 8'h08, 2'b00);
        // every selector code, external luma asserted
        for (int s = 0; s < 4; s++) begin
            wr(`OSC_IDX_PIN_SELECT, 8'(s), 2'b00);
            repeat (4) @(posedge aclk);
            chk("mux", pins, mix[s]);
        end
        // inverted external luma loses priority, internal shows through
        wr(`OSC_IDX_POLARITY, 8'h30, 2'b00);
        repeat (4) @(posedge aclk);
        chk("ext invert", pins, 5'h13);
        port <= 5'h06;
        wr(`OSC_IDX_PIN_SELECT, 8'hf8, 2'b00);
        repeat (4) @(posedge aclk);
        chk("port", pins, 5'h06);
        wr(`OSC_IDX_POLARITY, 8'h0f, 2'b00);
        repeat (4) @(posedge aclk);
        chk("port inverted", pins, 5'h19);
        wr(`OSC_IDX_SCAN_FORMAT, 8'h80, 2'b00);
        // registered copy shows one edge after the response
        @(posedge aclk);
        chk("dscan", dscan, 1);
        wr(`OSC_IDX_HSTART, 8'h5a, 2'b00);
        chk("hstart early", hstart, 8'h00);
        wr(`OSC_IDX_DISPLAY_CTRL, 8'h04, 2'b00);
        rdr(`OSC_IDX_DISPLAY_CTRL, rd);
        chk("busy", rd[2], 1);
        wait_load;
        chk("hstart", hstart, 8'h5a);
        rdr(`OSC_IDX_DISPLAY_CTRL, rd);
        chk("done", rd[2], 0);
        // inside the display area the load waits for the line end
        da <= 1;
        wr(`OSC_IDX_HSTART, 8'h10, 2'b00);
        wr(`OSC_IDX_DISPLAY_CTRL, 8'h04, 2'b00);
        repeat (200) @(posedge aclk);
        chk("line wait", hstart, 8'h5a);
        dle <= 1;
        @(posedge aclk);
        dle <= 0;
        wait_load;
        chk("hstart line", hstart, 8'h10);
        // start 2*16+22 dots after the sync pulse, plus one pipeline cycle
        while (!hfall) @(posedge aclk);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!cstart && n < 100);
        chk("char start", n, 2 * 16 + 22 + 1);
        // fifteen lines after the field start, counted in pairs
        while (!vfall) @(posedge aclk);
        repeat (15 * 64) @(posedge aclk);
        chk("line count", vcount, 7);
        finish_test;
    end
endmodule

// *** verif/osc_sync_source.sv ***
`timescale 1ns/1ns
module osc_sync_source (
    input wire logic aclk,
    output logic hsync_n,
    output logic vsync_n
);
    logic [5:0] dot = 6'h00;
    logic [3:0] line = 4'h0;
    // 64-dot lines, 16-line fields; short low sync pulses
    // progressive fields only, so no jitter filter setup is needed
    always @(posedge aclk) begin
        dot <= dot + 6'h01;
        if (dot == 6'h3f) line <= line + 4'h1;
    end
    assign hsync_n = (dot > 6'h03);
    assign vsync_n = (line != 4'h0);
endmodule
